// file: blsp_params.svh
// Timing counts, register offsets, field positions and reset values of the sequencer.
`ifndef BLSP_PARAMS_SVH
`define BLSP_PARAMS_SVH

// ----------------------------------------------------------------------------
// Clock and timing.
// ----------------------------------------------------------------------------
`define BLSP_CLK_NS          100
`define BLSP_PROBE_FREQ_KHZ  10
`define BLSP_PROBE_WIDTH_US  1
`define BLSP_SS_DELAY_MS     2
`define BLSP_SS_INTERVAL_MS  3
`define BLSP_UV_DELAY_US     30
`define BLSP_SW_FREQ_KHZ     230
`define BLSP_HICCUP_OFF_MS   2
`define BLSP_MAX_HICCUPS     4
`define BLSP_PROBE_CROSSINGS 4
`define BLSP_RAMP_STEPS      256

`define BLSP_PROBE_CYC   (1000000 / (`BLSP_PROBE_FREQ_KHZ * `BLSP_CLK_NS))
`define BLSP_PROBE_W_CYC (`BLSP_PROBE_WIDTH_US * 1000 / `BLSP_CLK_NS)
`define BLSP_SS_DLY_CYC  (`BLSP_SS_DELAY_MS * 1000000 / `BLSP_CLK_NS)
`define BLSP_RAMP_CYC    (`BLSP_SS_INTERVAL_MS * 1000000 / `BLSP_CLK_NS * 10 / 8)
`define BLSP_RAMP_STEP   (`BLSP_RAMP_CYC / `BLSP_RAMP_STEPS)
`define BLSP_UV_CYC      (`BLSP_UV_DELAY_US * 1000 / `BLSP_CLK_NS)
`define BLSP_PWM_CYC     (1000000 / (`BLSP_SW_FREQ_KHZ * `BLSP_CLK_NS))
`define BLSP_HICCUP_CYC  (`BLSP_HICCUP_OFF_MS * 1000000 / `BLSP_CLK_NS)

// ----------------------------------------------------------------------------
// Register map and fields.
// ----------------------------------------------------------------------------
`define BLSP_CTRL_OFS    12'h000
`define BLSP_STATUS_OFS  12'h004
`define BLSP_IRQSTAT_OFS 12'h008
`define BLSP_IRQMASK_OFS 12'h00C
`define BLSP_CTRL_RST    1'h1
`define BLSP_MASK_RST    6'h00
`define BLSP_EV_READY    0
`define BLSP_EV_OVER     1
`define BLSP_EV_BUCKUV   2
`define BLSP_EV_LDOUV    3
`define BLSP_EV_OVERCUR  4
`define BLSP_EV_SHUT     5

`endif

// file: blsp_pkg.sv
// Types shared by the start-up and protection sequencer.
`default_nettype none
package blsp_pkg;

    typedef enum logic [2:0] {
        OFF, PROBE, DELAY, RAMP, RUN, HICCUP, OVLATCH, SHUT
    } blsp_state_t;

    typedef struct packed {
        logic supplyGood;
        logic enableHigh;
        logic switchHigh;
        logic overVolt;
        logic buckUnder;
        logic ldoUnder;
        logic overCurrent;
        logic pwmDemand;
    } blsp_flags_t;

    typedef struct packed {
        logic highSideGate;
        logic lowSideGate;
        logic ldoGateDrive;
    } blsp_gates_t;

    typedef struct packed {
        blsp_flags_t sync1;
        blsp_flags_t sync2;
        logic        supPrev;
        logic        swPrev;
        blsp_state_t state;
        logic [16:0] tmr;
        logic [7:0]  ssLevel;
        logic [2:0]  crossCnt;
        logic [2:0]  ldoHicc;
        logic [2:0]  ocHicc;
        logic [8:0]  uvBuck;
        logic [8:0]  uvLdo;
        logic [5:0]  pwmCnt;
        blsp_gates_t gates;
        logic        irq;
        logic        runAllow;
        logic [5:0]  irqStat;
        logic [5:0]  irqMask;
        logic        hready;
        logic        hresp;
        logic [31:0] hrdata;
        logic        wrPend;
        logic [11:0] wrAddr;
    } blsp_regs_t;

endpackage
`default_nettype wire

// file: blsp_sequencer.sv
// Start-up, probing and protection sequencer for a buck plus linear regulator controller.
// What this block does
// - Run only while supply-good flag is high.
// - Enable pin low forces all gates low, except the low gate during overvoltage discharge.
// - Enable release starts probing, then soft-start.
// - Probe high-side gate at 10kHz, 1us.
// - Four switch-node crossings mean input present.
// - Wait 2ms, then ramp soft-start level.
// - One ramp sequences buck and linear outputs.
// - Switch at free-running 230kHz.
// - Overvoltage: linear off, high off, low on.
// - Overvoltage latch clears only on power-on.
// - Overvoltage before power-on drives low gate.
// - Undervoltage after soft-start, qualified for 30us.
// - Buck undervoltage hiccups without retry limit.
// - Shut down after fourth linear undervoltage hiccup.
// - Overcurrent counts only while low gate conducts.
// - Shut down after fourth overcurrent hiccup.
// - Ramp sized from 3ms 10-90% interval.
//
// Added by the designer: the register offsets and the AHB-Lite slave port.
`default_nettype none
`include "blsp_params.svh"

module blsp_sequencer #(
    parameter int SS_DLY_CYC = `BLSP_SS_DLY_CYC,
    parameter int HICCUP_CYC = `BLSP_HICCUP_CYC
) (
    // Clock and reset.
    input  wire  logic                 mclk,
    input  wire  logic                 nrst,
    // Comparator flags from the power stage.
    input  wire  blsp_pkg::blsp_flags_t flagsIn,
    // Gate commands and soft-start level.
    output var   blsp_pkg::blsp_gates_t gatesOut,
    output logic [7:0]                 softstartRamp,
    output logic                       irq,
    // AHB-Lite slave.
    input  wire  logic                 hsel,
    input  wire  logic [31:0]          haddr,
    input  wire  logic [1:0]           htrans,
    input  wire  logic                 hwrite,
    input  wire  logic [2:0]           hsize,
    input  wire  logic [31:0]          hwdata,
    input  wire  logic                 hready,
    output logic                       hreadyout,
    output logic                       hresp,
    output logic [31:0]                hrdata
);

    // ------------------------------------------------------------------------
    // Constants and elaboration checks.
    // ------------------------------------------------------------------------
    localparam logic [16:0] PROBE_CYC = 17'(`BLSP_PROBE_CYC);
    localparam logic [16:0] PROBE_W   = 17'(`BLSP_PROBE_W_CYC);
    localparam logic [16:0] RAMP_STEP = 17'(`BLSP_RAMP_STEP);
    localparam logic [8:0]  UV_CYC    = 9'(`BLSP_UV_CYC);
    localparam logic [5:0]  PWM_LAST  = 6'(`BLSP_PWM_CYC - 1);
    localparam logic [2:0]  MAX_HIC   = 3'(`BLSP_MAX_HICCUPS);
    localparam logic [2:0]  CROSS_N   = 3'(`BLSP_PROBE_CROSSINGS);
    localparam logic [16:0] SS_LAST   = 17'(SS_DLY_CYC - 1);
    localparam logic [16:0] HIC_LAST  = 17'(HICCUP_CYC - 1);

    if (SS_DLY_CYC < 1 || SS_DLY_CYC > 131072) begin : g_bad_ss
        $error("Soft-start delay count does not fit the timer.");
    end
    if (HICCUP_CYC < 1 || HICCUP_CYC > 131072) begin : g_bad_hic
        $error("Hiccup off count does not fit the timer.");
    end

    // ------------------------------------------------------------------------
    // State and next state.
    // ------------------------------------------------------------------------
    blsp_pkg::blsp_regs_t st;
    blsp_pkg::blsp_regs_t nxt;
    logic                 enabled;
    logic                 porRise;
    logic                 crossing;
    logic                 ocEvent;
    logic                 addrValid;
    logic                 operating;
    logic [5:0]           ev;
    logic [5:0]           clr;
    logic [11:0]          rdAddr;

    // ------------------------------------------------------------------------
    // Outputs.
    // ------------------------------------------------------------------------
    assign gatesOut      = st.gates;
    assign softstartRamp = st.ssLevel;
    assign irq           = st.irq;
    assign hreadyout     = st.hready;
    assign hresp         = st.hresp;
    assign hrdata        = st.hrdata;

    // ------------------------------------------------------------------------
    // Next-state logic.
    // ------------------------------------------------------------------------
    always_comb begin
        nxt = st;
        ev  = 6'h00;
        clr = 6'h00;
        nxt.sync1   = flagsIn;
        nxt.sync2   = st.sync1;
        nxt.supPrev = st.sync2.supplyGood;
        nxt.swPrev  = st.sync2.switchHigh;
        porRise     = st.sync2.supplyGood && !st.supPrev;
        crossing    = st.sync2.switchHigh != st.swPrev;
        ocEvent     = st.sync2.overCurrent && st.gates.lowSideGate;
        enabled     = st.sync2.supplyGood && st.sync2.enableHigh && st.runAllow;
        operating   = st.state != blsp_pkg::OFF && st.state != blsp_pkg::OVLATCH
                      && st.state != blsp_pkg::SHUT;
        nxt.tmr     = st.tmr + 17'h0001;
        nxt.pwmCnt  = (st.pwmCnt == PWM_LAST) ? 6'h00 : st.pwmCnt + 6'h01;

        case (st.state)
            blsp_pkg::OFF: begin
                nxt.tmr      = 17'h0000;
                nxt.crossCnt = 3'h0;
                nxt.ssLevel  = 8'h00;
                if (enabled) begin
                    nxt.state = blsp_pkg::PROBE;
                end
            end
            blsp_pkg::PROBE: begin
                if (st.tmr == PROBE_CYC - 17'h0001) begin
                    nxt.tmr = 17'h0000;
                end
                if (crossing) begin
                    nxt.crossCnt = st.crossCnt + 3'h1;
                    if (st.crossCnt == CROSS_N - 3'h1) begin
                        nxt.state = blsp_pkg::DELAY;
                        nxt.tmr   = 17'h0000;
                        ev[`BLSP_EV_READY] = 1'b1;
                    end
                end
            end
            blsp_pkg::DELAY: begin
                if (st.tmr == SS_LAST) begin
                    nxt.state   = blsp_pkg::RAMP;
                    nxt.tmr     = 17'h0000;
                    nxt.ssLevel = 8'h00;
                end
            end
            blsp_pkg::RAMP: begin
                if (st.tmr == RAMP_STEP - 17'h0001) begin
                    nxt.tmr = 17'h0000;
                    if (st.ssLevel == 8'hFF) begin
                        nxt.state  = blsp_pkg::RUN;
                        nxt.uvBuck = 9'h000;
                        nxt.uvLdo  = 9'h000;
                    end else begin
                        nxt.ssLevel = st.ssLevel + 8'h01;
                    end
                end
            end
            blsp_pkg::RUN: begin
                nxt.uvBuck = st.sync2.buckUnder ? st.uvBuck + 9'h001 : 9'h000;
                nxt.uvLdo  = st.sync2.ldoUnder ? st.uvLdo + 9'h001 : 9'h000;
                if (nxt.uvBuck == UV_CYC || nxt.uvLdo == UV_CYC) begin
                    nxt.state  = blsp_pkg::HICCUP;
                    nxt.tmr    = 17'h0000;
                    nxt.uvBuck = 9'h000;
                    nxt.uvLdo  = 9'h000;
                    if (st.sync2.ldoUnder && st.uvLdo == UV_CYC - 9'h001) begin
                        nxt.ldoHicc = st.ldoHicc + 3'h1;
                        ev[`BLSP_EV_LDOUV] = 1'b1;
                    end
                    ev[`BLSP_EV_BUCKUV] = st.sync2.buckUnder
                                          && st.uvBuck == UV_CYC - 9'h001;
                end
            end
            blsp_pkg::HICCUP: begin
                nxt.ssLevel = 8'h00;
                if (st.tmr == HIC_LAST) begin
                    nxt.tmr = 17'h0000;
                    if (st.ldoHicc == MAX_HIC || st.ocHicc == MAX_HIC) begin
                        nxt.state = blsp_pkg::SHUT;
                        ev[`BLSP_EV_SHUT] = 1'b1;
                    end else begin
                        nxt.state = blsp_pkg::DELAY;
                    end
                end
            end
            default: begin
                nxt.tmr = 17'h0000;
            end
        endcase

        if ((st.state == blsp_pkg::RAMP || st.state == blsp_pkg::RUN) && ocEvent) begin
            nxt.state   = blsp_pkg::HICCUP;
            nxt.tmr     = 17'h0000;
            nxt.ocHicc  = st.ocHicc + 3'h1;
            nxt.uvBuck  = 9'h000;
            nxt.uvLdo   = 9'h000;
            ev[`BLSP_EV_OVERCUR] = 1'b1;
        end
        if (st.sync2.supplyGood && st.sync2.overVolt && operating) begin
            nxt.state = blsp_pkg::OVLATCH;
            ev[`BLSP_EV_OVER] = 1'b1;
        end
        if (!enabled && operating) begin
            nxt.state = blsp_pkg::OFF;
        end
        if (!st.sync2.supplyGood) begin
            nxt.state = blsp_pkg::OFF;
        end
        if (porRise) begin
            nxt.ldoHicc  = 3'h0;
            nxt.ocHicc   = 3'h0;
            nxt.crossCnt = 3'h0;
        end
        // Undervoltage counters only run in the run state.
        if (nxt.state != blsp_pkg::RUN) begin
            nxt.uvBuck = 9'h000;
            nxt.uvLdo  = 9'h000;
        end

        // Gate commands follow the next state.
        nxt.gates = '0;
        case (nxt.state)
            blsp_pkg::PROBE: begin
                nxt.gates.highSideGate = nxt.tmr < PROBE_W;
            end
            blsp_pkg::RAMP, blsp_pkg::RUN: begin
                nxt.gates.highSideGate = st.sync2.pwmDemand && st.pwmCnt != PWM_LAST;
                nxt.gates.lowSideGate  = !st.sync2.pwmDemand || st.pwmCnt == PWM_LAST;
                nxt.gates.ldoGateDrive = 1'b1;
            end
            blsp_pkg::OVLATCH: begin
                nxt.gates.lowSideGate = 1'b1;
            end
            blsp_pkg::OFF: begin
                nxt.gates.lowSideGate = !st.sync2.supplyGood && st.sync2.overVolt;
            end
            default: begin
                nxt.gates = '0;
            end
        endcase

        // Bus slave: zero wait states, always OKAY.
        nxt.hready = 1'b1;
        nxt.hresp  = 1'b0;
        addrValid  = hsel && htrans[1] && hready;
        rdAddr     = haddr[11:0];
        nxt.wrPend = addrValid && hwrite && haddr[31:12] == 20'h0_0000;
        nxt.wrAddr = rdAddr;
        if (st.wrPend) begin
            if (st.wrAddr == `BLSP_CTRL_OFS) begin
                nxt.runAllow = hwdata[0];
            end else if (st.wrAddr == `BLSP_IRQSTAT_OFS) begin
                clr = hwdata[5:0];
            end else if (st.wrAddr == `BLSP_IRQMASK_OFS) begin
                nxt.irqMask = hwdata[5:0];
            end
        end
        if (addrValid && !hwrite) begin
            if (haddr[31:12] != 20'h0_0000) begin
                nxt.hrdata = 32'h0000_0000;
            end else if (rdAddr == `BLSP_CTRL_OFS) begin
                nxt.hrdata = {31'h0000_0000, st.runAllow};
            end else if (rdAddr == `BLSP_STATUS_OFS) begin
                nxt.hrdata = {12'h000, st.ssLevel, st.ocHicc, st.ldoHicc,
                              st.crossCnt, st.state};
            end else if (rdAddr == `BLSP_IRQSTAT_OFS) begin
                nxt.hrdata = {26'h000_0000, st.irqStat};
            end else if (rdAddr == `BLSP_IRQMASK_OFS) begin
                nxt.hrdata = {26'h000_0000, st.irqMask};
            end else begin
                nxt.hrdata = 32'h0000_0000;
            end
        end
        // Sticky events: a new event wins over a same-cycle clear.
        nxt.irqStat = (st.irqStat & ~clr) | ev;
        nxt.irq     = |(nxt.irqStat & nxt.irqMask);
    end

    // ------------------------------------------------------------------------
    // State register.
    // ------------------------------------------------------------------------
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            st          <= '0;
            st.state    <= blsp_pkg::OFF;
            st.runAllow <= `BLSP_CTRL_RST;
            st.irqMask  <= `BLSP_MASK_RST;
            st.hready   <= 1'b1;
        end else begin
            st <= nxt;
        end
    end

    // ------------------------------------------------------------------------
    // Assertions.
    // ------------------------------------------------------------------------
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!nrst);

    chk_off_gates_low: assert property (
        st.state == blsp_pkg::OFF |-> !st.gates.highSideGate && !st.gates.ldoGateDrive)
        else $error("Gates not low while off.");
    chk_ov_discharge: assert property (
        st.state == blsp_pkg::OVLATCH |->
            st.gates.lowSideGate && !st.gates.highSideGate && !st.gates.ldoGateDrive)
        else $error("Overvoltage latch does not discharge.");
    chk_ov_latch_sticky: assert property (
        st.state == blsp_pkg::OVLATCH && st.sync2.supplyGood |=> st.state == blsp_pkg::OVLATCH)
        else $error("Overvoltage latch left without power-on.");
    chk_probe_width: assert property (
        st.state == blsp_pkg::PROBE && st.gates.highSideGate |-> st.tmr < PROBE_W)
        else $error("Probe pulse too wide.");
    chk_probe_count: assert property (
        $past(st.state) == blsp_pkg::PROBE && st.state == blsp_pkg::DELAY |->
            st.crossCnt == CROSS_N)
        else $error("Input declared present at wrong crossing count.");
    chk_uv_bound: assert property (
        st.state != blsp_pkg::RUN |-> st.uvBuck == 9'h000 && st.uvLdo == 9'h000)
        else $error("Undervoltage counted outside run.");
    chk_shut_count: assert property (
        $rose(st.state == blsp_pkg::SHUT) |-> st.ldoHicc == MAX_HIC || st.ocHicc == MAX_HIC)
        else $error("Shutdown before fourth hiccup.");
    chk_oc_gated: assert property (
        st.ocHicc == $past(st.ocHicc) + 3'h1 |->
            $past(st.gates.lowSideGate) && $past(st.sync2.overCurrent))
        else $error("Overcurrent counted without low gate.");
    chk_supply_loss: assert property (
        !st.sync2.supplyGood |=> st.state == blsp_pkg::OFF)
        else $error("Supply loss did not stop the sequence.");
    chk_disable_off: assert property (
        !st.sync2.enableHigh && st.state != blsp_pkg::OFF && st.state != blsp_pkg::OVLATCH
            && st.state != blsp_pkg::SHUT |=> st.state == blsp_pkg::OFF)
        else $error("Disable did not stop the sequence.");
    chk_probe_period: assert property (
        st.state == blsp_pkg::PROBE |-> st.tmr < PROBE_CYC)
        else $error("Probe period counter out of range.");
    chk_shared_ramp: assert property (
        st.state == blsp_pkg::RUN |-> st.ssLevel == 8'hFF && st.gates.ldoGateDrive)
        else $error("Run entered before the shared ramp finished.");
    chk_early_discharge: assert property (
        !st.sync2.supplyGood && st.sync2.overVolt |=> st.gates.lowSideGate)
        else $error("Overvoltage without supply does not discharge.");
    chk_buck_unlimited: assert property (
        st.state == blsp_pkg::RUN && !st.sync2.ldoUnder |=> st.ldoHicc == $past(st.ldoHicc))
        else $error("Buck undervoltage counted toward shutdown.");
    chk_irq_level: assert property (
        ##1 st.irq == |(st.irqStat & st.irqMask))
        else $error("Interrupt output disagrees with status and mask.");

endmodule // blsp_sequencer
`default_nettype wire

// file: blsp_power_stage.sv
// Power stage model: switch node answering high-side gate pulses.
`default_nettype none
module blsp_power_stage (
    // Clock and reset.
    input  wire logic                  mclk,
    input  wire logic                  nrst,
    // Gate commands and test controls.
    input  wire blsp_pkg::blsp_gates_t gates,
    input  wire logic                  inputPresent,
    input  wire logic                  slowAnswer,
    // Switch node above its crossing level.
    output logic                       swNode
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [3:0] holdCnt;
    logic       hsPrev;
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            holdCnt <= 4'h0;
            hsPrev  <= 1'b0;
        end else begin
            hsPrev <= gates.highSideGate;
            if (gates.highSideGate && !hsPrev && inputPresent) begin
                holdCnt <= slowAnswer ? 4'hC : 4'h3;
            end else if (holdCnt != 4'h0) begin
                holdCnt <= holdCnt - 4'h1;
            end
        end
    end
    assign swNode = (holdCnt != 4'h0);
endmodule // blsp_power_stage
`default_nettype wire

// file: blsp_sequencer_tb.sv
// Self-checking bench for the start-up and protection sequencer.
`default_nettype none
module blsp_sequencer_tb;
    timeunit 1ns;
    timeprecision 1ns;
    // ------------------------------------------------------------------------
    // Signals.
    // ------------------------------------------------------------------------
    logic                  mclk, nrst, hsel, hwrite, hreadyout, hresp, irq;
    logic                  swNode, present, slow, randPwm, pwmBit;
    logic [1:0]            htrans;
    logic [2:0]            hsize;
    logic [31:0]           haddr, hwdata, hrdata, lfsr, rd, wval;
    logic [7:0]            ramp;
    blsp_pkg::blsp_flags_t flg, flagsIn;
    blsp_pkg::blsp_gates_t gates;
    int                    bad_count, comparisons, expIrq, hi, per;

    always_comb begin
        flagsIn = flg;
        flagsIn.switchHigh = swNode;
        flagsIn.pwmDemand = pwmBit;
    end
    blsp_sequencer #(.SS_DLY_CYC(20), .HICCUP_CYC(20)) blsp_sequencer_inst (
        .mclk(mclk), .nrst(nrst), .flagsIn(flagsIn), .gatesOut(gates),
        .softstartRamp(ramp), .irq(irq), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata));
    blsp_power_stage blsp_power_stage_inst (
        .mclk(mclk), .nrst(nrst), .gates(gates), .inputPresent(present),
        .slowAnswer(slow), .swNode(swNode));

    // ------------------------------------------------------------------------
    // Clock, random source and tasks.
    // ------------------------------------------------------------------------
    initial begin
        mclk = 1'b0;
        forever #50 mclk = ~mclk;
    end
    function automatic logic [31:0] nextRand(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction
    always @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            lfsr   <= 32'h0000_a360;
            pwmBit <= 1'b1;
        end else begin
            lfsr   <= nextRand(lfsr);
            pwmBit <= randPwm ? lfsr[0] : 1'b1;
        end
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            bad_count++;
            $display("unexpected at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        htrans <= 2'b10;
        haddr <= a;
        hwrite <= wr;
        do begin @(posedge mclk); end while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= wr ? d : 32'h0000_0000;
        do begin @(posedge mclk); end while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask
    task automatic waitState(input int s, input int lim);
        for (int t = 0; t < lim; t += 2) begin
            bus(1'b0, 32'h0000_0004, 32'h0000_0000);
            if (rd[2:0] === s[2:0]) break;
        end
    endtask
    task automatic measure();
        int n;
        n = 0;
        hi = 0;
        per = 0;
        while (gates.highSideGate !== 1'b0 && n < 3000) begin @(posedge mclk); n++; end
        while (gates.highSideGate !== 1'b1 && n < 3000) begin @(posedge mclk); n++; end
        while (gates.highSideGate === 1'b1 && per < 3000) begin @(posedge mclk); hi++; per++; end
        while (gates.highSideGate !== 1'b1 && per < 3000) begin @(posedge mclk); per++; end
    endtask
    task automatic conclude();
        $display("comparisons %0d mismatches %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    initial begin
        #(95000 * 100);
        bad_count++;
        conclude();
    end

    // ------------------------------------------------------------------------
    // Main sequence.
    // ------------------------------------------------------------------------
    initial begin
        flg = 8'h80;
        {present, slow, randPwm, hsel, hwrite, nrst} = 6'h08;
        {htrans, hsize, haddr, hwdata} = {2'b00, 3'b010, 64'h0};
        bad_count = 0;
        comparisons = 0;
        expIrq = 1;
        repeat (2) @(posedge mclk);
        nrst <= 1'b1;
        @(posedge mclk);
        check({hreadyout, hresp, irq, gates, ramp}, 32'h0000_2000);
        bus(1'b0, 32'h0000_0000, 32'h0000_0000);
        check(rd, 32'h0000_0001);
        bus(1'b1, 32'h0000_0010, lfsr);
        bus(1'b0, 32'h0000_0010, 32'h0000_0000);
        check(rd, 32'h0000_0000);
        wval = lfsr;
        bus(1'b1, 32'h0000_000C, wval);
        check(irq, 1'b0);
        bus(1'b0, 32'h0000_000C, 32'h0000_0000);
        check(rd, {26'h000_0000, wval[5:0]});
        bus(1'b1, 32'h0000_000C, 32'h0000_0000);
        flg.enableHigh <= 1'b1;
        measure();
        check(hi, 10);
        check(per, 1000);
        waitState(1, 10);
        check(rd[5:0], 6'h01);
        flg.enableHigh <= 1'b0;
        repeat (6) @(posedge mclk);
        hi = 0;
        repeat (1100) begin @(posedge mclk); if (gates !== 3'b000) hi++; end
        check(hi, 0);
        waitState(0, 4);
        check(rd[5:0], 6'h00);
        present <= 1'b1;
        slow <= 1'b1;
        flg.enableHigh <= 1'b1;
        waitState(2, 2200);
        check(rd[2:0], 3'h2);
        check(irq, 1'b0);
        waitState(3, 40);
        check(rd[2:0], 3'h3);
        repeat (18688) @(posedge mclk);
        check(ramp >= 8'h7C && ramp <= 8'h84, 1'b1);
        waitState(4, 19000);
        check(rd[2:0], 3'h4);
        check({rd[19:12], ramp}, 16'hFFFF);
        randPwm <= 1'b0;
        repeat (6) @(posedge mclk);
        measure();
        check(per, 43);
        check(hi, 42);
        check(gates.ldoGateDrive, 1'b1);
        flg.ldoUnder <= 1'b1;
        repeat (250) @(posedge mclk);
        flg.ldoUnder <= 1'b0;
        waitState(4, 4);
        check(rd[2:0], 3'h4);
        flg.ldoUnder <= 1'b1;
        waitState(5, 340);
        check({rd[8:6], rd[2:0]}, 6'h0D);
        expIrq = expIrq | 8;
        flg.ldoUnder <= 1'b0;
        bus(1'b1, 32'h0000_000C, 32'h0000_003F);
        repeat (2) @(posedge mclk);
        check(irq, 1'b1);
        bus(1'b0, 32'h0000_0008, 32'h0000_0000);
        check(rd, expIrq);
        bus(1'b1, 32'h0000_0008, expIrq);
        bus(1'b0, 32'h0000_0008, 32'h0000_0000);
        repeat (2) @(posedge mclk);
        check(rd, 32'h0000_0000);
        check(irq, 1'b0);
        waitState(2, 60);
        check(rd[2:0], 3'h2);
        flg.overVolt <= 1'b1;
        waitState(6, 20);
        repeat (2) @(posedge mclk);
        check({rd[2:0], gates}, 6'h32);
        check(irq, 1'b1);
        flg.overVolt <= 1'b0;
        flg.enableHigh <= 1'b0;
        repeat (30) @(posedge mclk);
        waitState(6, 2);
        check(rd[2:0], 3'h6);
        flg.supplyGood <= 1'b0;
        present <= 1'b0;
        waitState(0, 20);
        check(rd[2:0], 3'h0);
        flg.overVolt <= 1'b1;
        repeat (6) @(posedge mclk);
        check(gates.lowSideGate, 1'b1);
        flg.overVolt <= 1'b0;
        repeat (6) @(posedge mclk);
        flg.supplyGood <= 1'b1;
        flg.enableHigh <= 1'b1;
        waitState(1, 20);
        check(rd[11:0], 12'h001);
        present <= 1'b1;
        waitState(4, 41000);
        check(rd[2:0], 3'h4);
        flg.buckUnder <= 1'b1;
        waitState(5, 340);
        check({rd[11:6], rd[2:0]}, 9'h005);
        flg.buckUnder <= 1'b0;
        waitState(2, 60);
        check(rd[2:0], 3'h2);
        bus(1'b0, 32'h0000_0008, 32'h0000_0000);
        check(rd[2], 1'b1);
        flg.overCurrent <= 1'b1;
        waitState(7, 1000);
        check({rd[11:6], rd[2:0]}, 9'h107);
        bus(1'b0, 32'h0000_0008, 32'h0000_0000);
        check(rd[5:4], 2'b11);
        check(gates, 3'b000);
        conclude();
    end
endmodule // blsp_sequencer_tb
`default_nettype wire
